// ### verilog/esl_status.sv
// Standard event status latch, enable mask and status byte summary
`timescale 1ns/1ps
`default_nettype none
module esl_status
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,

    // Instrument commands, one-cycle strobes
    input wire logic clear_status_cmd,
    input wire logic mask_write_cmd,
    input wire logic [esl_pkg::ESL_BYTE_W-1:0] mask_write_data,
    input wire logic mask_query_cmd,
    input wire logic latch_query_cmd,
    input wire logic op_done_cmd,

    // Event sources
    input wire logic err_valid,
    input wire logic [esl_pkg::ESL_CODE_W-1:0] err_code,
    input wire logic ques_fault_set,
    input wire logic ops_idle,

    // Other status byte bits, summaries from outside
    input wire logic [esl_pkg::ESL_BYTE_W-1:0] status_other,

    // Query answer
    output logic query_valid,
    output logic [esl_pkg::ESL_BYTE_W-1:0] query_data,

    // Register views
    output logic [esl_pkg::ESL_BYTE_W-1:0] standard_event_latch,
    output logic [esl_pkg::ESL_BYTE_W-1:0] event_enable_mask,
    output logic [esl_pkg::ESL_BYTE_W-1:0] status_summary_byte,
    output logic event_summary_flag,
    output logic op_pending,

    // Clear strobes to neighbouring status blocks
    output logic error_queue_flush,
    output logic event_regs_clear
);
    import esl_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [7:0] latch;    // Sticky event bits
        logic [7:0] mask;     // Summary enable mask
        esl_opc_e operation_done_flag;        // Done tracking
        logic resp_valid;     // Answer strobe
        logic [7:0] resp;     // Answer byte
        logic [7:0] stb;      // Status byte view
        logic summary;        // Event summary copy
        logic flush;          // Error queue flush strobe
        logic clr;            // Event register clear strobe
    } esl_state_s;

    esl_state_s state;       // Registered state
    esl_state_s next_state;  // Next state

    // Carrier to the classifier
    esl_err_if err_bus ();

    // Classified error bits
    logic [7:0] class_bits;
    // All bits raised this cycle
    logic [7:0] set_bits;
    // All bits cleared this cycle
    logic [7:0] clr_bits;

    // Drive the error report into the classifier
    assign err_bus.err_valid = err_valid;
    assign err_bus.err_code = err_code;
    assign class_bits = err_bus.err_bits;

    // Error code classifier
    esl_err_classify u_classify
    (
        .err (err_bus.classifier)
    );

    // Overlap of latch and mask gives the summary
    function automatic logic esl_summary(input logic [7:0] latch, input logic [7:0] mask);
        return |(latch & mask);
    endfunction

    // Next state computation
    always_comb
    begin
        next_state = state;
        set_bits = class_bits;
        clr_bits = 8'h00;
        next_state.resp_valid = 1'b0;
        next_state.flush = 1'b0;
        next_state.clr = 1'b0;

        // Device fault with questionable bit newly set
        if (ques_fault_set)
        begin
            set_bits[ESL_BIT_DEV_ERR] = 1'b1;
        end

        // Done tracking state machine
        case (state.operation_done_flag)
            ESL_OPC_IDLE:
            begin
                // Nothing outstanding
                if (op_done_cmd)
                begin
                    next_state.operation_done_flag = ESL_OPC_PENDING;
                    clr_bits[ESL_BIT_OP_DONE] = 1'b1;
                end
            end
            ESL_OPC_PENDING:
            begin
                // Waiting for all operations to finish
                if (op_done_cmd)
                begin
                    clr_bits[ESL_BIT_OP_DONE] = 1'b1;
                end
                else if (ops_idle)
                begin
                    next_state.operation_done_flag = ESL_OPC_IDLE;
                    set_bits[ESL_BIT_OP_DONE] = 1'b1;
                end
            end
            default:
            begin
                // Recover from an illegal code
                next_state.operation_done_flag = ESL_OPC_IDLE;
            end
        endcase

        // Command handling, clear-status first
        if (clear_status_cmd)
        begin
            next_state.flush = 1'b1;
            next_state.clr = 1'b1;
            next_state.operation_done_flag = ESL_OPC_IDLE;
            clr_bits = 8'hff;
        end
        else if (latch_query_cmd)
        begin
            // Answer with contents, then empty
            next_state.resp_valid = 1'b1;
            next_state.resp = state.latch;
            clr_bits = 8'hff;
        end
        else if (mask_query_cmd)
        begin
            // Mask answered untouched
            next_state.resp_valid = 1'b1;
            next_state.resp = state.mask;
        end
        else if (mask_write_cmd)
        begin
            // Whole byte, so always in 0..255
            next_state.mask = mask_write_data;
        end

        // Sticky latch, a new event wins over a clear
        next_state.latch = ((state.latch & ~clr_bits) | set_bits) & ESL_LATCH_USED;

        // Summary and status byte from the next values
        next_state.summary = esl_summary(next_state.latch, next_state.mask);
        next_state.stb = status_other;
        next_state.stb[ESL_BIT_SUMMARY] = next_state.summary;
        if (clear_status_cmd)
        begin
            // Status byte cleared with the event registers
            next_state.stb = ESL_STB_RST;
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state.latch <= ESL_LATCH_RST;
            state.mask <= ESL_MASK_RST;
            state.operation_done_flag <= ESL_OPC_IDLE;
            state.resp_valid <= 1'b0;
            state.resp <= 8'h00;
            state.stb <= ESL_STB_RST;
            state.summary <= 1'b0;
            state.flush <= 1'b0;
            state.clr <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    assign query_valid = state.resp_valid;
    assign query_data = state.resp;
    assign standard_event_latch = state.latch;
    assign event_enable_mask = state.mask;
    assign status_summary_byte = state.stb;
    assign event_summary_flag = state.summary;
    assign op_pending = state.operation_done_flag[1];
    assign error_queue_flush = state.flush;
    assign event_regs_clear = state.clr;
endmodule
`default_nettype wire

// ### verilog/esl_pkg.sv
// Constants and types shared by the standard event status logic
`default_nettype none
package esl_pkg;

    // Width of the event latch, mask and status byte
    localparam int unsigned ESL_BYTE_W = 8;
    // Width of an error code magnitude
    localparam int unsigned ESL_CODE_W = 10;

    // Event latch bit positions
    localparam int unsigned ESL_BIT_CMD_ERR = 5;
    localparam int unsigned ESL_BIT_EXE_ERR = 4;
    localparam int unsigned ESL_BIT_DEV_ERR = 3;
    localparam int unsigned ESL_BIT_QRY_ERR = 2;
    localparam int unsigned ESL_BIT_OP_DONE = 0;
    // Event summary position in the status byte
    localparam int unsigned ESL_BIT_SUMMARY = 5;

    // Reset values
    localparam logic [7:0] ESL_MASK_RST = 8'h00;
    localparam logic [7:0] ESL_LATCH_RST = 8'h00;
    localparam logic [7:0] ESL_STB_RST = 8'h00;

    // Bits that can ever be latched; 7, 6 and 1 are unused
    localparam logic [7:0] ESL_LATCH_USED = 8'h3d;

    // Error code class bounds (hundreds ranges)
    localparam logic [9:0] ESL_CLASS1_LO = 10'h064;
    localparam logic [9:0] ESL_CLASS2_LO = 10'h0c8;
    localparam logic [9:0] ESL_CLASS3_LO = 10'h12c;
    localparam logic [9:0] ESL_CLASS4_LO = 10'h190;
    localparam logic [9:0] ESL_CLASS4_HI = 10'h1f3;

    // Operation complete tracking, one-hot
    typedef enum logic [1:0] {
        ESL_OPC_IDLE = 2'b01,
        ESL_OPC_PENDING = 2'b10
    } esl_opc_e;

endpackage
`default_nettype wire

// ### verilog/esl_err_if.sv
// Error report carrier between the status top and its classifier
`timescale 1ns/1ps
`default_nettype none
interface esl_err_if;
    // Error report strobe
    logic err_valid;
    // Error code magnitude
    logic [9:0] err_code;
    // Event latch bits the error sets
    logic [7:0] err_bits;

    // Classifier side
    modport classifier (input err_valid, input err_code, output err_bits);
    // Status logic side
    modport user (output err_valid, output err_code, input err_bits);
endinterface
`default_nettype wire

// ### verilog/esl_err_classify.sv
// Maps a reported error code onto event latch bits
`timescale 1ns/1ps
`default_nettype none
module esl_err_classify
(
    // Error report in, bits out
    esl_err_if.classifier err
);
    import esl_pkg::*;

    // Hundreds range of a code to one event bit
    function automatic logic [7:0] esl_class_bits(input logic [9:0] code);
        logic [7:0] bits;
        bits = 8'h00;
        if (code >= ESL_CLASS1_LO && code < ESL_CLASS2_LO)
        begin
            bits[ESL_BIT_CMD_ERR] = 1'b1;
        end
        else if (code >= ESL_CLASS2_LO && code < ESL_CLASS3_LO)
        begin
            bits[ESL_BIT_EXE_ERR] = 1'b1;
        end
        else if (code >= ESL_CLASS3_LO && code < ESL_CLASS4_LO)
        begin
            bits[ESL_BIT_DEV_ERR] = 1'b1;
        end
        else if (code >= ESL_CLASS4_LO && code <= ESL_CLASS4_HI)
        begin
            bits[ESL_BIT_QRY_ERR] = 1'b1;
        end
        return bits;
    endfunction

    // Only a valid report produces bits
    always_comb
    begin
        err.err_bits = err.err_valid ? esl_class_bits(err.err_code) : 8'h00;
    end
endmodule
`default_nettype wire

// ### dv/esl_host.sv
// Host controller model issuing instrument commands
`timescale 1ns/1ps
`default_nettype none
module esl_host
(
    // Clock
    input wire logic clock,
    // Commands, mask data and event sources
    output logic [4:0] cmd,
    output logic [7:0] wdata,
    output logic err_valid,
    output logic [9:0] err_code,
    output logic ques_fault_set,
    output logic ops_idle,
    output logic [7:0] status_other
);
    // Quiet bus from time zero
    initial {cmd, wdata, err_valid, err_code, ques_fault_set, ops_idle, status_other} = '0;
    // One-cycle command strobe; mask data is a byte, so 0..255 only
    task automatic send(input logic [4:0] c, input logic [7:0] d);
    begin
        // Idle edge first, so back-to-back calls never retoggle the strobe
        @(posedge clock);
        #1 cmd = c;
        wdata = d;
        @(posedge clock);
        #1 cmd = 5'h00;
    end
    endtask
    // One-cycle error report or supply fault
    task automatic fault(input logic [9:0] c, input logic q);
    begin
        // Idle edge first, as for commands
        @(posedge clock);
        #1 err_valid = !q;
        err_code = c;
        ques_fault_set = q;
        @(posedge clock);
        #1 {err_valid, ques_fault_set} = 2'b00;
    end
    endtask
endmodule
`default_nettype wire

// ### dv/esl_status_sva.sv
// Checker for the standard event status logic
`timescale 1ns/1ps
`default_nettype none
module esl_status_sva
(
    // Clock, reset, commands
    input wire logic clock,
    input wire logic reset,
    input wire logic clear_status_cmd,
    input wire logic mask_write_cmd,
    input wire logic [7:0] mask_write_data,
    input wire logic mask_query_cmd,
    input wire logic latch_query_cmd,
    input wire logic op_done_cmd,
    input wire logic err_valid,
    input wire logic ques_fault_set,
    // Outputs watched
    input wire logic query_valid,
    input wire logic [7:0] query_data,
    input wire logic [7:0] standard_event_latch,
    input wire logic [7:0] event_enable_mask,
    input wire logic [7:0] status_summary_byte,
    input wire logic event_summary_flag,
    input wire logic op_pending,
    input wire logic error_queue_flush,
    input wire logic event_regs_clear
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    property p_flush; clear_status_cmd |=> error_queue_flush && event_regs_clear; endproperty
    a_flush: assert property (p_flush) else $error("no flush");
    property p_idle; clear_status_cmd |=> !op_pending; endproperty
    a_idle: assert property (p_idle) else $error("done tracking busy");
    property p_clr; clear_status_cmd && !err_valid && !ques_fault_set |=> status_summary_byte == 8'h00
        && (standard_event_latch & 8'h3c) == 8'h00 && $stable(event_enable_mask); endproperty
    a_clr: assert property (p_clr) else $error("clear wrong");
    property p_esb; event_summary_flag == |(standard_event_latch & event_enable_mask); endproperty
    a_esb: assert property (p_esb) else $error("summary wrong");
    property p_mwr; mask_write_cmd && !clear_status_cmd && !latch_query_cmd && !mask_query_cmd
        |=> event_enable_mask == $past(mask_write_data); endproperty
    a_mwr: assert property (p_mwr) else $error("mask write");
    property p_mq; mask_query_cmd && !clear_status_cmd && !latch_query_cmd
        |=> query_valid && query_data == $past(event_enable_mask); endproperty
    a_mq: assert property (p_mq) else $error("mask query");
    property p_lq; latch_query_cmd && !clear_status_cmd
        |=> query_valid && query_data == $past(standard_event_latch); endproperty
    a_lq: assert property (p_lq) else $error("latch query");
    property p_nu; (standard_event_latch & 8'hc2) == 8'h00; endproperty
    a_nu: assert property (p_nu) else $error("unused bit set");
    property p_done; op_done_cmd && !clear_status_cmd |=> op_pending && !standard_event_latch[0]; endproperty
    a_done: assert property (p_done) else $error("done command");
endmodule
`default_nettype wire

// ### dv/esl_status_bench.sv
// Self-checking bench for the standard event status logic
`timescale 1ns/1ps
`default_nettype none
module esl_status_bench;
    import esl_pkg::*;
    // Error code row and the latch it should give
    typedef struct packed {logic [9:0] code; logic q; logic [7:0] exp;} esl_row_s;
    esl_row_s rows [10] = '{'{10'h064, 1'b0, 8'h20}, '{10'h0c7, 1'b0, 8'h20}, '{10'h0fa, 1'b0, 8'h10},
        '{10'h12c, 1'b0, 8'h08}, '{10'h18f, 1'b0, 8'h08}, '{10'h190, 1'b0, 8'h04}, '{10'h1f3, 1'b0, 8'h04},
        '{10'h063, 1'b0, 8'h00}, '{10'h1f4, 1'b0, 8'h00}, '{10'h000, 1'b1, 8'h08}};
    localparam logic [4:0] CLR = 5'h10, MWR = 5'h08, MQ = 5'h04, LQ = 5'h02, OPD = 5'h01;
    logic clock = 0;
    logic reset = 1;
    logic [4:0] cmd;
    logic [7:0] wdata, status_other, query_data, standard_event_latch, event_enable_mask, status_summary_byte;
    logic [9:0] err_code;
    logic err_valid, ques_fault_set, ops_idle, query_valid, event_summary_flag, op_pending;
    logic error_queue_flush, event_regs_clear;
    int err_count = 0;
    int checks_done = 0;
    // 200 MHz clock
    always #2.5 clock = ~clock;
    esl_host u_host (.clock, .cmd, .wdata, .err_valid, .err_code, .ques_fault_set, .ops_idle, .status_other);
    esl_status u_dut (.clock, .reset, .clear_status_cmd(cmd[4]), .mask_write_cmd(cmd[3]),
        .mask_write_data(wdata), .mask_query_cmd(cmd[2]), .latch_query_cmd(cmd[1]), .op_done_cmd(cmd[0]),
        .err_valid, .err_code, .ques_fault_set, .ops_idle, .status_other, .query_valid, .query_data,
        .standard_event_latch, .event_enable_mask, .status_summary_byte, .event_summary_flag, .op_pending,
        .error_queue_flush, .event_regs_clear);
    // Compare one byte and count it
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    begin
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    // Counts, verdict, end of run
    task automatic finish_test;
    begin
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clock);
        #1 reset = 0;
        chk("mask", 8'h00, event_enable_mask);
        chk("latch", 8'h00, standard_event_latch);
        // Error classes, each read back and cleared
        foreach (rows[k])
        begin
            u_host.fault(rows[k].code, rows[k].q);
            u_host.send(LQ, 8'h00);
            chk("class", rows[k].exp, query_data);
        end
        u_host.send(MWR, 8'hff);
        u_host.send(MQ, 8'h00);
        chk("maskq", 8'hff, query_data);
        chk("qvalid", 8'h01, {7'h00, query_valid});
        chk("mask", 8'hff, event_enable_mask);
        u_host.fault(10'h0fa, 1'b0);
        chk("stb", 8'h20, status_summary_byte);
        chk("esb", 8'h01, {7'h00, event_summary_flag});
        u_host.fault(10'h096, 1'b0);
        chk("sticky", 8'h30, standard_event_latch);
        u_host.send(MWR, 8'h01);
        chk("stb", 8'h00, status_summary_byte);
        chk("esb", 8'h00, {7'h00, event_summary_flag});
        u_host.send(LQ, 8'h00);
        chk("latchq", 8'h30, query_data);
        chk("latch", 8'h00, standard_event_latch);
        // Operation complete tracking
        u_host.send(OPD, 8'h00);
        chk("pend", 8'h01, {7'h00, op_pending});
        u_host.ops_idle = 1;
        // Bounded wait, outputs looked at only after they settle
        for (int i = 0; i < 20 && standard_event_latch[0] !== 1'b1; i++)
        begin
            @(posedge clock);
            #1;
        end
        chk("done", 8'h01, standard_event_latch);
        if (standard_event_latch[0] !== 1'b1)
            finish_test();
        u_host.ops_idle = 0;
        // Clear-status with everything busy
        u_host.send(OPD, 8'h00);
        u_host.fault(10'h12c, 1'b0);
        u_host.status_other = 8'hff;
        u_host.send(CLR, 8'h00);
        chk("flush", 8'h03, {6'h00, error_queue_flush, event_regs_clear});
        chk("latch", 8'h00, standard_event_latch);
        chk("stb", 8'h00, status_summary_byte);
        chk("pend", 8'h00, {7'h00, op_pending});
        chk("mask", 8'h01, event_enable_mask);
        @(posedge clock);
        #1 chk("stb", 8'hdf, status_summary_byte);
        finish_test();
    end
endmodule
bind esl_status esl_status_sva u_sva (.clock(clock), .reset(reset), .clear_status_cmd(clear_status_cmd),
    .mask_write_cmd(mask_write_cmd), .mask_write_data(mask_write_data), .mask_query_cmd(mask_query_cmd),
    .latch_query_cmd(latch_query_cmd), .op_done_cmd(op_done_cmd), .err_valid(err_valid),
    .ques_fault_set(ques_fault_set), .query_valid(query_valid), .query_data(query_data),
    .standard_event_latch(standard_event_latch), .event_enable_mask(event_enable_mask),
    .status_summary_byte(status_summary_byte), .event_summary_flag(event_summary_flag),
    .op_pending(op_pending), .error_queue_flush(error_queue_flush), .event_regs_clear(event_regs_clear));
`default_nettype wire
